// ---- hw/cies_pkg.sv ----
// Shared constants and types for the instruction exception sequencer
package cies_pkg;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned VEC_W = 8;
    typedef logic [WORD_W-1:0] cies_word_t;
    typedef logic [VEC_W-1:0] cies_vec_t;

    // Vector numbers for the fixed causes; values are arbitrary defaults
    localparam cies_vec_t VEC_GEN_ILLEGAL = 8'h10;
    localparam cies_vec_t VEC_SLOT_ILLEGAL = 8'h11;
    localparam cies_vec_t VEC_ADDR_ERR = 8'h12;

    // Stack step and alignment of stack and vector accesses
    localparam cies_word_t STACK_STEP = 32'h0000_0004;
    localparam logic [1:0] ALIGN_MASK = 2'h3;
    localparam int unsigned VEC_SHIFT = 2;
    localparam cies_word_t WORD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_TRAP,
        CAUSE_SLOT,
        CAUSE_GEN,
        CAUSE_ADDR,
        CAUSE_INT
    } cies_cause_e;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PUSH_SR,
        S_PUSH_PC,
        S_VEC_READ
    } cies_state_e;
endpackage

// ---- hw/cies_addr_unit.sv ----
// Stack decrement, vector address and alignment checks
`timescale 1ns/100ps
module cies_addr_unit
    import cies_pkg::*;
(
    // Operands
    input wire cies_pkg::cies_word_t sp,
    input wire cies_pkg::cies_word_t vector_table_base,
    input wire cies_pkg::cies_vec_t vec,
    // Results
    output cies_pkg::cies_word_t sp_dec,
    output cies_pkg::cies_word_t vec_addr,
    output logic sp_misaligned,
    output logic vbr_misaligned
);
    // Pointer is stepped even when misaligned, so it stays misaligned
    assign sp_dec = sp - STACK_STEP;
    assign vec_addr = vector_table_base + (cies_word_t'(vec) << VEC_SHIFT);
    assign sp_misaligned = |(sp[1:0] & ALIGN_MASK);
    assign vbr_misaligned = |(vector_table_base[1:0] & ALIGN_MASK);
endmodule

// ---- hw/cies_sequencer.sv ----
// Exception entry sequencer between instruction decoder and memory bus
`timescale 1ns/100ps
module cies_sequencer
    import cies_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CE,
    // Decoder side
    input wire logic DEC_VALID,
    input wire cies_pkg::cies_word_t DEC_PC,
    input wire cies_pkg::cies_word_t DEC_NEXT_PC,
    input wire logic DEC_UNDEFINED,
    input wire logic DEC_PC_WRITE,
    input wire logic DEC_DELAYED_BRANCH,
    input wire cies_pkg::cies_word_t DEC_BRANCH_TARGET,
    input wire logic DEC_TRAP,
    input wire cies_pkg::cies_vec_t DEC_TRAP_VEC,
    input wire logic DEC_CSR_ACCESS,
    output logic DEC_HOLD,
    output logic DEC_IN_SLOT,
    // Exception sources
    input wire logic INT_REQ,
    input wire cies_pkg::cies_vec_t INT_VEC,
    output logic INT_ACK,
    input wire logic ADDR_ERR_REQ,
    output logic ADDR_ERR_PENDING,
    // Core registers
    input wire cies_pkg::cies_word_t STATUS_WORD,
    input wire cies_pkg::cies_word_t STACK_POINTER,
    input wire cies_pkg::cies_word_t VECTOR_TABLE_BASE,
    output logic SP_WE,
    output cies_pkg::cies_word_t SP_NEXT,
    // Memory bus
    output logic MEM_REQ,
    output logic MEM_WE,
    output cies_pkg::cies_word_t MEM_ADDR,
    output cies_pkg::cies_word_t MEM_WDATA,
    input wire logic MEM_ACK,
    input wire cies_pkg::cies_word_t MEM_RDATA,
    // Branch to handler
    output logic BRANCH_VALID,
    output cies_pkg::cies_word_t BRANCH_ADDR,
    output logic EXC_BUSY
);
    import cies_pkg::*;

    cies_state_e state_ff, nxt_state;
    cies_cause_e cause_ff, nxt_cause;
    cies_vec_t vec_ff, nxt_vec;
    cies_word_t pc_save_ff, nxt_pc_save;
    cies_word_t sp_ff, nxt_sp;
    cies_word_t target_ff, nxt_target;
    cies_word_t mem_addr_ff, nxt_mem_addr;
    cies_word_t mem_wdata_ff, nxt_mem_wdata;
    cies_word_t branch_addr_ff, nxt_branch_addr;
    logic mem_req_ff, nxt_mem_req;
    logic mem_we_ff, nxt_mem_we;
    logic branch_valid_ff, nxt_branch_valid;
    logic sp_we_ff, nxt_sp_we;
    logic slot_ff, nxt_slot;
    logic after_csr_ff, nxt_after_csr;
    logic pend_ff, nxt_pend;

    logic idle, dec_ok, slot_ill, gen_ill, trap_hit, addr_hit, int_hit;
    logic take, exec, err;
    cies_cause_e take_cause;
    cies_vec_t take_vec;
    cies_word_t take_pc;
    cies_word_t au_sp_in, au_sp_dec, au_vec_addr;
    logic au_sp_mis, au_vbr_mis;

    // Idle uses the live pointer; during entry the working copy
    assign au_sp_in = idle ? STACK_POINTER : sp_ff;

    cies_addr_unit u_addr (
        .sp(au_sp_in),
        .vector_table_base(VECTOR_TABLE_BASE),
        .vec(vec_ff),
        .sp_dec(au_sp_dec),
        .vec_addr(au_vec_addr),
        .sp_misaligned(au_sp_mis),
        .vbr_misaligned(au_vbr_mis)
    );

    assign idle = (state_ff == S_IDLE);
    assign dec_ok = CE & DEC_VALID & idle;
    assign slot_ill = slot_ff & (DEC_UNDEFINED | DEC_PC_WRITE);
    assign gen_ill = ~slot_ff & DEC_UNDEFINED;
    assign trap_hit = ~slot_ff & DEC_TRAP & ~DEC_UNDEFINED;
    // Pending error taken only at a later decode, so its bus cycle is over
    assign addr_hit = ~slot_ff & pend_ff;
    assign int_hit = ~slot_ff & ~after_csr_ff & INT_REQ;

    // Pending errors belong to older instructions, so they come first
    always_comb begin
        take_cause = CAUSE_NONE;
        take_vec = VEC_GEN_ILLEGAL;
        take_pc = DEC_PC;
        if (slot_ill) begin
            take_cause = CAUSE_SLOT;
            take_vec = VEC_SLOT_ILLEGAL;
            take_pc = target_ff;
        end else if (addr_hit) begin
            take_cause = CAUSE_ADDR;
            take_vec = VEC_ADDR_ERR;
        end else if (int_hit) begin
            take_cause = CAUSE_INT;
            take_vec = INT_VEC;
        end else if (gen_ill) begin
            take_cause = CAUSE_GEN;
            take_vec = VEC_GEN_ILLEGAL;
            take_pc = DEC_PC;
        end else if (trap_hit) begin
            take_cause = CAUSE_TRAP;
            take_vec = DEC_TRAP_VEC;
            take_pc = DEC_NEXT_PC;
        end
    end

    assign take = dec_ok & (take_cause != CAUSE_NONE);
    assign exec = dec_ok & (take_cause == CAUSE_NONE);

    // Decoder waits during entry and drops an instruction that traps
    assign DEC_HOLD = CE & DEC_VALID & (~idle | take);
    assign INT_ACK = take & (take_cause == CAUSE_INT);
    assign DEC_IN_SLOT = slot_ff;
    assign ADDR_ERR_PENDING = pend_ff;
    assign EXC_BUSY = ~idle;
    assign MEM_REQ = mem_req_ff;
    assign MEM_WE = mem_we_ff;
    assign MEM_ADDR = mem_addr_ff;
    assign MEM_WDATA = mem_wdata_ff;
    assign BRANCH_VALID = branch_valid_ff;
    assign BRANCH_ADDR = branch_addr_ff;
    assign SP_WE = sp_we_ff;
    assign SP_NEXT = sp_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cause = cause_ff;
        nxt_vec = vec_ff;
        nxt_pc_save = pc_save_ff;
        nxt_sp = sp_ff;
        nxt_target = target_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_mem_req = mem_req_ff;
        nxt_mem_we = mem_we_ff;
        nxt_branch_addr = branch_addr_ff;
        nxt_branch_valid = 1'b0;
        nxt_sp_we = 1'b0;
        nxt_slot = slot_ff;
        nxt_after_csr = after_csr_ff;
        nxt_pend = pend_ff;
        err = 1'b0;
        if (exec) begin
            nxt_slot = DEC_DELAYED_BRANCH;
            nxt_after_csr = DEC_CSR_ACCESS;
            if (DEC_DELAYED_BRANCH) begin
                nxt_target = DEC_BRANCH_TARGET;
            end
        end
        if (take) begin
            nxt_slot = 1'b0;
            nxt_after_csr = 1'b0;
            if (take_cause == CAUSE_ADDR) begin
                nxt_pend = 1'b0;
            end
        end
        case (state_ff)
            S_IDLE: begin
                if (take) begin
                    nxt_cause = take_cause;
                    nxt_vec = take_vec;
                    nxt_pc_save = take_pc;
                    nxt_sp = au_sp_dec;
                    nxt_mem_req = 1'b1;
                    nxt_mem_we = 1'b1;
                    nxt_mem_addr = au_sp_dec;
                    nxt_mem_wdata = STATUS_WORD;
                    err = au_sp_mis & (take_cause != CAUSE_ADDR);
                    nxt_state = S_PUSH_SR;
                end
            end
            S_PUSH_SR: begin
                if (MEM_ACK) begin
                    nxt_sp = au_sp_dec;
                    nxt_mem_addr = au_sp_dec;
                    nxt_mem_wdata = pc_save_ff;
                    err = au_sp_mis & (cause_ff != CAUSE_ADDR);
                    nxt_state = S_PUSH_PC;
                end
            end
            S_PUSH_PC: begin
                if (MEM_ACK) begin
                    nxt_mem_we = 1'b0;
                    nxt_mem_addr = au_vec_addr;
                    nxt_mem_wdata = WORD_ZERO;
                    err = au_vbr_mis & (cause_ff != CAUSE_ADDR);
                    nxt_state = S_VEC_READ;
                end
            end
            S_VEC_READ: begin
                if (MEM_ACK) begin
                    nxt_mem_req = 1'b0;
                    nxt_branch_valid = 1'b1;
                    nxt_branch_addr = MEM_RDATA;
                    nxt_sp_we = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
                nxt_mem_req = 1'b0;
            end
        endcase
        // New errors win over the clear of the accepted one
        if (err | ADDR_ERR_REQ) begin
            nxt_pend = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= S_IDLE;
            cause_ff <= CAUSE_NONE;
            vec_ff <= VEC_GEN_ILLEGAL;
            pc_save_ff <= WORD_ZERO;
            sp_ff <= WORD_ZERO;
            target_ff <= WORD_ZERO;
            mem_addr_ff <= WORD_ZERO;
            mem_wdata_ff <= WORD_ZERO;
            branch_addr_ff <= WORD_ZERO;
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            branch_valid_ff <= 1'b0;
            sp_we_ff <= 1'b0;
            slot_ff <= 1'b0;
            after_csr_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else if (CE) begin
            state_ff <= nxt_state;
            cause_ff <= nxt_cause;
            vec_ff <= nxt_vec;
            pc_save_ff <= nxt_pc_save;
            sp_ff <= nxt_sp;
            target_ff <= nxt_target;
            mem_addr_ff <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
            branch_addr_ff <= nxt_branch_addr;
            mem_req_ff <= nxt_mem_req;
            mem_we_ff <= nxt_mem_we;
            branch_valid_ff <= nxt_branch_valid;
            sp_we_ff <= nxt_sp_we;
            slot_ff <= nxt_slot;
            after_csr_ff <= nxt_after_csr;
            pend_ff <= nxt_pend;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    chk_trap_saves_next: assert property (
        take && take_cause == CAUSE_TRAP |=>
        pc_save_ff == $past(DEC_NEXT_PC) && vec_ff == $past(DEC_TRAP_VEC))
        else $error("trap entry saved wrong address or vector");
    chk_slot_undef_start: assert property (
        dec_ok && slot_ff && DEC_UNDEFINED |-> DEC_HOLD ##1
        state_ff == S_PUSH_SR && vec_ff == VEC_SLOT_ILLEGAL)
        else $error("undefined slot opcode did not start slot entry");
    chk_slot_pcwrite_start: assert property (
        dec_ok && slot_ff && DEC_PC_WRITE |-> take &&
        take_cause == CAUSE_SLOT)
        else $error("counter write in slot not trapped");
    chk_push_order_seq: assert property (
        CE && state_ff == S_PUSH_SR && MEM_ACK |=> state_ff == S_PUSH_PC &&
        MEM_WE && MEM_WDATA == pc_save_ff)
        else $error("counter push did not follow status push");
    chk_slot_pc_target: assert property (
        take && take_cause == CAUSE_SLOT |=> pc_save_ff == $past(target_ff))
        else $error("slot entry did not save branch target");
    chk_gen_pc_self: assert property (
        take && take_cause == CAUSE_GEN |=> pc_save_ff == $past(DEC_PC))
        else $error("general illegal saved wrong address");
    chk_slot_no_accept: assert property (
        slot_ff |-> !INT_ACK && !(take && take_cause == CAUSE_ADDR))
        else $error("exception accepted in delay slot");
    chk_pend_holds: assert property (
        pend_ff && !take |=> pend_ff)
        else $error("pending address error lost");
    chk_csr_int_block: assert property (
        after_csr_ff && dec_ok && INT_REQ && !pend_ff |-> !INT_ACK)
        else $error("interrupt taken after register move");
    chk_sp_misalign_err: assert property (
        CE && state_ff == S_PUSH_SR && MEM_ACK && sp_ff[1:0] != 2'h0 &&
        cause_ff != CAUSE_ADDR |=> pend_ff)
        else $error("misaligned stacking raised no error");
    chk_addr_err_quiet: assert property (
        !idle && cause_ff == CAUSE_ADDR && !pend_ff && !ADDR_ERR_REQ |=>
        !pend_ff)
        else $error("error raised during address-error entry");
    chk_unaligned_write: assert property (
        state_ff == S_PUSH_SR |-> MEM_REQ && MEM_WE && MEM_ADDR == sp_ff)
        else $error("stack write address is not the pointer");
    chk_vec_address: assert property (
        CE && state_ff == S_PUSH_PC && MEM_ACK |=> !MEM_WE && MEM_ADDR ==
        $past(VECTOR_TABLE_BASE) + (cies_word_t'($past(vec_ff)) << VEC_SHIFT))
        else $error("vector read at wrong address");

    cov_trap_entry: cover property (take && take_cause == CAUSE_TRAP);
    cov_slot_entry: cover property (take && take_cause == CAUSE_SLOT);
    cov_chain_addr: cover property (BRANCH_VALID && pend_ff);
    cov_int_entry: cover property (INT_ACK);
endmodule

// ---- tb/cies_mem_model.sv ----
// Memory bus partner answering stacking writes and vector reads
`timescale 1ns/100ps
module cies_mem_model
    import cies_pkg::*;
(
    // Clock, reset and answer pacing
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] wait_cycles,
    // Bus from the sequencer
    input wire logic mem_req,
    input wire logic mem_we,
    input wire cies_pkg::cies_word_t mem_addr,
    output logic mem_ack,
    output cies_pkg::cies_word_t mem_rdata
);
    logic [1:0] cnt_ff;
    // Read data toggles except on read answers so a stale word never looks valid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= WORD_ZERO;
        end else if (mem_req && !mem_ack && cnt_ff == wait_cycles) begin
            cnt_ff <= 2'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem_we ? ~mem_rdata : {mem_addr[15:0], 16'h0C00};
        end else begin
            cnt_ff <= (mem_req && !mem_ack) ? cnt_ff + 2'h1 : 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ---- tb/tb_cpu_instruction_exception_sequencer.sv ----
// Self-checking bench for the exception entry sequencer
`timescale 1ns/100ps
module tb_cpu_instruction_exception_sequencer;
    import cies_pkg::*;
    localparam logic [4:0] K_NOP = 5'h00, K_UND = 5'h10, K_PCW = 5'h08;
    localparam logic [4:0] K_DBR = 5'h0C, K_TRAP = 5'h0A, K_CSR = 5'h01;
    // Slot kinds packed low to high: undefined, pc write, branch, trap
    localparam logic [19:0] SLOT_K = {K_TRAP, K_DBR, K_PCW, K_UND};
    logic CLOCK = 1'b0, RST_B = 1'b0, CE = 1'b0, DEC_VALID = 1'b0;
    logic DEC_UNDEFINED = 1'b0, DEC_PC_WRITE = 1'b0, DEC_TRAP = 1'b0;
    logic DEC_DELAYED_BRANCH = 1'b0, DEC_CSR_ACCESS = 1'b0;
    logic INT_REQ = 1'b0, ADDR_ERR_REQ = 1'b0;
    cies_word_t DEC_PC = WORD_ZERO, DEC_NEXT_PC = WORD_ZERO;
    cies_word_t DEC_BRANCH_TARGET = WORD_ZERO, STATUS_WORD = WORD_ZERO;
    cies_word_t STACK_POINTER = WORD_ZERO, VECTOR_TABLE_BASE = WORD_ZERO;
    cies_vec_t DEC_TRAP_VEC = 8'h00, INT_VEC = 8'h00, m_tv;
    logic [1:0] pace = 2'h0;
    logic DEC_HOLD, DEC_IN_SLOT, INT_ACK, ADDR_ERR_PENDING, SP_WE, MEM_REQ;
    logic MEM_WE, MEM_ACK, BRANCH_VALID, EXC_BUSY, hold, iack, pend, slot;
    cies_word_t SP_NEXT, MEM_ADDR, MEM_WDATA, MEM_RDATA, BRANCH_ADDR;
    cies_word_t m_sp, m_vbr, m_sr, m_tgt, bpc;
    cies_word_t exp_a[$], exp_d[$], exp_b[$], exp_s[$];
    logic exp_w[$], exp_x[$];
    int err_count = 0, cmp_count = 0, seed, i, v;

    always #10 CLOCK = ~CLOCK;

    cies_sequencer DUT (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE),
        .DEC_VALID(DEC_VALID), .DEC_PC(DEC_PC), .DEC_NEXT_PC(DEC_NEXT_PC),
        .DEC_UNDEFINED(DEC_UNDEFINED), .DEC_PC_WRITE(DEC_PC_WRITE),
        .DEC_DELAYED_BRANCH(DEC_DELAYED_BRANCH),
        .DEC_BRANCH_TARGET(DEC_BRANCH_TARGET), .DEC_TRAP(DEC_TRAP),
        .DEC_TRAP_VEC(DEC_TRAP_VEC), .DEC_CSR_ACCESS(DEC_CSR_ACCESS),
        .DEC_HOLD(DEC_HOLD), .DEC_IN_SLOT(DEC_IN_SLOT), .INT_REQ(INT_REQ),
        .INT_VEC(INT_VEC), .INT_ACK(INT_ACK), .ADDR_ERR_REQ(ADDR_ERR_REQ),
        .ADDR_ERR_PENDING(ADDR_ERR_PENDING), .STATUS_WORD(STATUS_WORD),
        .STACK_POINTER(STACK_POINTER), .VECTOR_TABLE_BASE(VECTOR_TABLE_BASE),
        .SP_WE(SP_WE), .SP_NEXT(SP_NEXT), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA), .BRANCH_VALID(BRANCH_VALID),
        .BRANCH_ADDR(BRANCH_ADDR), .EXC_BUSY(EXC_BUSY));

    cies_mem_model mem (.clk(CLOCK), .rst_b(RST_B), .wait_cycles(pace),
        .mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_addr(MEM_ADDR),
        .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));

    task chk_word(input string nm, input cies_word_t e, input cies_word_t g);
        begin
            cmp_count++;
            if (g !== e) begin
                err_count++;
                $display("FAIL %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task chk_bit(input string nm, input logic e, input logic g);
        begin
            cmp_count++;
            if (g !== e) begin
                err_count++;
                $display("FAIL %s expected %b seen %b", nm, e, g);
            end
        end
    endtask

    task acc(input cies_word_t a, input logic w, input cies_word_t d,
             input logic x);
        begin
            exp_a.push_back(a);
            exp_w.push_back(w);
            exp_d.push_back(d);
            exp_x.push_back(x);
        end
    endtask

    // Reference entry: two pushes below the stack, then one vector read
    task expect_entry(input cies_word_t pc, input cies_vec_t vec);
        cies_word_t va;
        logic mis;
        begin
            va = m_vbr + {22'h0, vec, 2'h0};
            mis = (m_sp[1:0] & ALIGN_MASK) != 2'h0;
            acc(m_sp - STACK_STEP, 1'b1, m_sr, mis);
            acc(m_sp - STACK_STEP - STACK_STEP, 1'b1, pc, mis);
            acc(va, 1'b0, WORD_ZERO, 1'b1);
            exp_b.push_back({va[15:0], 16'h0C00});
            m_sp = m_sp - STACK_STEP - STACK_STEP;
            exp_s.push_back(m_sp);
        end
    endtask

    always @(posedge CLOCK) begin
        if (SP_WE === 1'b1)
            STACK_POINTER <= SP_NEXT;
        if (RST_B && MEM_REQ === 1'b1 && MEM_ACK === 1'b1) begin
            chk_bit("access_expected", 1'b1, exp_a.size() != 0);
            if (exp_a.size() != 0) begin
                chk_bit("mem_we", exp_w.pop_front(), MEM_WE);
                chk_word("mem_addr", exp_a.pop_front(), MEM_ADDR);
                if (exp_x.pop_front())
                    void'(exp_d.pop_front());
                else
                    chk_word("mem_wdata", exp_d.pop_front(), MEM_WDATA);
            end
        end
        if (BRANCH_VALID === 1'b1) begin
            chk_bit("branch_expected", 1'b1, exp_b.size() != 0);
            if (exp_b.size() != 0) begin
                chk_word("branch_addr", exp_b.pop_front(), BRANCH_ADDR);
                chk_word("sp_next", exp_s.pop_front(), SP_NEXT);
            end
        end
    end

    task start(input logic [1:0] mis);
        begin
            @(posedge CLOCK);
            m_sp = ($urandom & 32'h0000_FFFC) + {30'h0, mis[0], 1'b0};
            m_vbr = ($urandom & 32'h00FF_F000) + {30'h0, mis[1], 1'b0};
            m_sr = $urandom;
            m_tgt = $urandom & 32'h0FFF_FFFE;
            bpc = $urandom & 32'h0FFF_FFFE;
            m_tv = cies_vec_t'($urandom);
            STACK_POINTER <= m_sp;
            VECTOR_TABLE_BASE <= m_vbr;
            STATUS_WORD <= m_sr;
            DEC_BRANCH_TARGET <= m_tgt;
            DEC_TRAP_VEC <= m_tv;
            INT_VEC <= cies_vec_t'($urandom);
            pace <= 2'($urandom_range(3, 0));
        end
    endtask

    task dec(input logic [4:0] k, input cies_word_t pc, input logic irq,
             input logic ae);
        begin
            @(posedge CLOCK);
            DEC_VALID <= 1'b1;
            DEC_PC <= pc;
            DEC_NEXT_PC <= pc + 32'h0000_0002;
            {DEC_UNDEFINED, DEC_PC_WRITE, DEC_DELAYED_BRANCH, DEC_TRAP,
                DEC_CSR_ACCESS} <= k;
            INT_REQ <= irq;
            ADDR_ERR_REQ <= ae;
            #2;
            hold = DEC_HOLD;
            iack = INT_ACK;
            pend = ADDR_ERR_PENDING;
            slot = DEC_IN_SLOT;
        end
    endtask

    task settle;
        int n;
        begin
            @(posedge CLOCK);
            DEC_VALID <= 1'b0;
            INT_REQ <= 1'b0;
            ADDR_ERR_REQ <= 1'b0;
            n = 0;
            #1;
            while (EXC_BUSY !== 1'b0 && n < 60) begin
                @(posedge CLOCK);
                #1;
                n++;
            end
            @(posedge CLOCK);
            #1;
            chk_bit("busy_drop", 1'b1, n < 60);
            chk_bit("entry_done", 1'b1, exp_a.size() + exp_b.size() == 0);
        end
    endtask

    task final_report;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        #200000;
        err_count++;
        final_report();
    end

    initial begin
        seed = $urandom(46877);
        repeat (3) @(posedge CLOCK);
        RST_B <= 1'b1;
        CE <= 1'b1;
        repeat (2) begin
            start(2'h0);
            dec(K_TRAP, bpc, 1'b0, 1'b0);
            chk_bit("hold_trap", 1'b1, hold);
            expect_entry(bpc + 32'h0000_0002, m_tv);
            settle();
            $display("test trap done");
            for (i = 0; i < 4; i++) begin
                start(2'h0);
                dec(K_DBR, bpc, 1'b0, 1'b0);
                chk_bit("hold_branch", 1'b0, hold);
                dec(SLOT_K[i*5 +: 5], bpc + 32'h0000_0002, 1'b0, 1'b0);
                chk_bit("in_slot", 1'b1, slot);
                chk_bit("hold_slot", 1'b1, hold);
                expect_entry(m_tgt, VEC_SLOT_ILLEGAL);
                settle();
            end
            $display("test slot illegal done");
            start(2'h0);
            // Enable low first: nothing may be taken while frozen
            CE <= 1'b0;
            dec(K_UND, bpc, 1'b0, 1'b0);
            chk_bit("hold_frozen", 1'b0, hold);
            @(posedge CLOCK);
            CE <= 1'b1;
            #2;
            chk_bit("busy_frozen", 1'b0, EXC_BUSY);
            chk_bit("hold_undef", 1'b1, DEC_HOLD);
            expect_entry(bpc, VEC_GEN_ILLEGAL);
            settle();
            $display("test general illegal done");
            for (v = 0; v < 4; v++) begin
                start(2'h0);
                dec(v[0] ? K_CSR : K_DBR, bpc, 1'b0, v[1]);
                dec(K_NOP, bpc + 32'h0000_0002, !v[1], 1'b0);
                chk_bit("hold_next", v[0] & v[1], hold);
                chk_bit("int_ack_next", 1'b0, iack);
                if (v[0] & v[1]) begin
                    expect_entry(bpc + 32'h0000_0002, VEC_ADDR_ERR);
                end else begin
                    chk_bit("pend_kept", v[1], pend);
                    dec(K_NOP, bpc + 32'h0000_0004, !v[1], 1'b0);
                    chk_bit("taken_late", 1'b1, hold);
                    chk_bit("int_ack_late", !v[1], iack);
                    expect_entry(bpc + 32'h0000_0004,
                        v[1] ? VEC_ADDR_ERR : INT_VEC);
                end
                settle();
            end
            $display("test refusal done");
            for (v = 1; v < 3; v++) begin
                start(v[1:0]);
                dec(K_TRAP, bpc, 1'b0, 1'b0);
                expect_entry(bpc + 32'h0000_0002, m_tv);
                settle();
                chk_bit("pend_after", 1'b1, ADDR_ERR_PENDING);
                dec(K_NOP, m_tgt, 1'b0, 1'b0);
                chk_bit("hold_ae", 1'b1, hold);
                expect_entry(m_tgt, VEC_ADDR_ERR);
                settle();
                chk_bit("pend_clear", 1'b0, ADDR_ERR_PENDING);
                dec(K_NOP, m_tgt + 32'h0000_0002, 1'b0, 1'b0);
                chk_bit("hold_clear", 1'b0, hold);
            end
            $display("test misaligned done");
        end
        final_report();
    end
endmodule
